// ---- design/ptst_pattern.sv ----
`timescale 1ns/100ps
`default_nettype none
module ptst_pattern (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic soft_rst,
  // Control
  input wire logic pattern_enable,
  input wire logic [1:0] choice,
  input wire logic gap_select,
  // Line driver
  output logic drv_active,
  output logic drv_level
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [3:0] {
    PTST_P_IDLE = 4'h1,
    PTST_P_BURST = 4'h2,
    PTST_P_MARK = 4'h4,
    PTST_P_GAP = 4'h8
  } ptst_pstate_t;

  ptst_pstate_t state_reg, state_next;
  logic [8:0] cnt_reg, cnt_next;   // Cycles in current state
  logic [6:0] lfsr_reg, lfsr_next; // Burst data source
  logic level_reg, level_next;
  logic phase_reg;                 // Manchester half-bit phase

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire is_tone = (choice == ptst_pkg::PTST_CH_TONE);
  wire is_link = (choice == ptst_pkg::PTST_CH_LINK);
  wire [8:0] gap_len = gap_select ? 9'(ptst_pkg::GAP_LONG_CYC)
                                  : 9'(ptst_pkg::GAP_SHORT_CYC);
  wire [8:0] mark_len = (choice == ptst_pkg::PTST_CH_DATA_B)
                      ? 9'(ptst_pkg::MARK_B_CYC) : 9'(ptst_pkg::MARK_A_CYC);
  wire [8:0] burst_len = is_link ? 9'(ptst_pkg::NLP_CYC)
                                 : 9'(2 * ptst_pkg::DATA_BITS);
  wire cnt_last_gap = (cnt_reg == gap_len - 9'h001);
  wire cnt_last_mark = (cnt_reg == mark_len - 9'h001);
  wire cnt_last_burst = (cnt_reg == burst_len - 9'h001);
  // First half carries the inverse bit, second half the bit
  wire manch_bit = phase_reg ? lfsr_reg[0] : ~lfsr_reg[0];

  // Next state and line level
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + 9'h001;
    lfsr_next = lfsr_reg;
    level_next = 1'b0;
    unique case (state_reg)
      PTST_P_IDLE: begin
        cnt_next = 9'h000;
        if (pattern_enable) begin
          state_next = PTST_P_BURST;
        end
      end
      PTST_P_BURST: begin
        if (is_tone) begin
          // Constant ones: level toggles every half bit, a 10 MHz tone
          level_next = phase_reg;
          cnt_next = 9'h000;
        end else if (is_link) begin
          level_next = 1'b1;
          if (cnt_last_burst) begin
            state_next = PTST_P_GAP;
            cnt_next = 9'h000;
          end
        end else begin
          level_next = manch_bit;
          if (phase_reg) begin
            lfsr_next = {lfsr_reg[5:0], lfsr_reg[6] ^ lfsr_reg[5]};
          end
          if (cnt_last_burst) begin
            state_next = PTST_P_MARK;
            cnt_next = 9'h000;
          end
        end
      end
      PTST_P_MARK: begin
        level_next = 1'b1;
        if (cnt_last_mark) begin
          state_next = PTST_P_GAP;
          cnt_next = 9'h000;
        end
      end
      PTST_P_GAP: begin
        if (cnt_last_gap) begin
          state_next = PTST_P_BURST;
          cnt_next = 9'h000;
        end
      end
      default: begin
        state_next = PTST_P_IDLE;
      end
    endcase
    // Disabling stops the pattern at once
    if (!pattern_enable) begin
      state_next = PTST_P_IDLE;
      level_next = 1'b0;
    end
  end

  // Registers; soft reset restarts the sequence
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= PTST_P_IDLE;
      cnt_reg <= 9'h000;
      lfsr_reg <= ptst_pkg::PATT_SEED;
      level_reg <= 1'b0;
      phase_reg <= 1'b0;
    end else if (soft_rst) begin
      state_reg <= PTST_P_IDLE;
      cnt_reg <= 9'h000;
      lfsr_reg <= ptst_pkg::PATT_SEED;
      level_reg <= 1'b0;
      phase_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      lfsr_reg <= lfsr_next;
      level_reg <= level_next;
      // Phase is zero in the first burst cycle, so every bit gets both halves
      phase_reg <= (state_reg == PTST_P_BURST && state_next == PTST_P_BURST) ? ~phase_reg : 1'b0;
    end
  end

  assign drv_active = (state_reg != PTST_P_IDLE);
  assign drv_level = level_reg;

endmodule
`default_nettype wire

// ---- design/ptst_pkg.sv ----
package ptst_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [4:0] ADDR_DRV_TEST = 5'h1B; // Driver test and self-test ext.
  localparam logic [4:0] ADDR_CTRL2 = 5'h1C;    // Second control register

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int TALLY_MSB = 15;
  localparam int TALLY_LSB = 8;
  localparam int CTRL_MSB = 7;      // Writable control byte top
  localparam int NONSTOP_BIT = 5;
  localparam int PATT_EN_BIT = 4;
  localparam int GAP_SEL_BIT = 2;
  localparam int CHOICE_MSB = 1;
  localparam int SOFT_RST_BIT = 9;

  // ----------------------------------------
  // Reset and limit values
  // ----------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] TALLY_ZERO = 8'h00;
  localparam logic [7:0] TALLY_MAX = 8'hFF;
  localparam logic [7:0] TALLY_ONE = 8'h01;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int GAP_SHORT_NS = 10000;  // Gap select clear
  localparam int GAP_LONG_NS = 15000;   // Gap select set
  localparam int NLP_WIDTH_NS = 100;    // Link pulse width
  // Gaps are least times, so round up
  localparam int GAP_SHORT_CYC = (GAP_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_LONG_CYC = (GAP_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NLP_CYC = (NLP_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_BITS = 16;        // Manchester bits per test burst
  localparam int MARK_A_CYC = 5;        // End marker variant a, high time
  localparam int MARK_B_CYC = 7;        // End marker variant b, high time
  localparam int SOFT_RST_CYC = 16;     // Length of internal soft reset
  localparam int PKT_NIBBLES = 64;      // Self-test packet length
  localparam int PKT_GAP_NIBBLES = 24;  // Idle between self-test packets
  localparam logic [6:0] PATT_SEED = 7'h5A;
  localparam logic [14:0] PRBS_SEED = 15'h7FFF;

  // ----------------------------------------
  // Pattern choices
  // ----------------------------------------
  typedef enum logic [1:0] {
    PTST_CH_DATA_A = 2'h0,
    PTST_CH_DATA_B = 2'h1,
    PTST_CH_LINK = 2'h2,
    PTST_CH_TONE = 2'h3
  } ptst_choice_t;

endpackage

// ---- design/ptst_top.sv ----
// Contract
// - Count errored nibbles during self-test, 8 bits
// - Restarting self-test clears the error tally
// - Tally saturates at all ones
// - Nonstop mode sends gapless pseudo-random data
// - Nonstop mode acts only with main self-test controls
// - Driver patterns only while pattern enable set
// - Gap select: 15 us set, 10 us clear
// - Choice 00/01 data plus marker, 10 link
// - Choice 11 sends Manchester ones tone
// - Soft reset resets logic, keeps registers
// - Unused control bits ignore writes, read zero; driver test bits 7, 6 and 3 still store writes and read back
// - Babble guard disable acts only in 10M TP
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module ptst_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Main self-test controls from the main control register
  input wire logic selftest_start,
  input wire logic selftest_run,
  // Receive checker of the self-test
  input wire logic rx_nibble_valid,
  input wire logic rx_nibble_error,
  // Babble guard setting and link mode
  input wire logic babble_guard_disable,
  input wire logic ten_meg_tp_mode,
  output logic babble_guard_enable,
  // Self-test transmit path
  output logic selftest_tx_en,
  output logic [3:0] selftest_tx_data,
  // Line driver test pattern
  output logic line_driver_active,
  output logic line_driver_level,
  // Internal soft reset to the rest of the device
  output logic soft_reset_out
);

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [7:0] ctrl_reg;          // Writable byte of driver test reg
  logic [7:0] tally_reg;         // Self-test mismatch tally
  logic [7:0] tally_next;
  logic [4:0] srst_cnt_reg;      // Soft reset cycles left
  logic [4:0] srst_cnt_next;
  logic [15:0] rdata_reg;        // Read data, one cycle after strobe
  logic [15:0] rdata_next;

  // ----------------------------------------
  // Self-test transmit state
  // ----------------------------------------
  typedef enum logic [2:0] {
    PTST_T_OFF = 3'h1,
    PTST_T_SEND = 3'h2,
    PTST_T_GAP = 3'h4
  } ptst_tstate_t;

  ptst_tstate_t tx_state_reg, tx_state_next;
  logic [6:0] tx_cnt_reg, tx_cnt_next;     // Nibbles in current state
  logic [14:0] prbs_reg, prbs_next;        // Pseudo-random source
  logic [3:0] tx_data_reg, tx_data_next;   // Registered data output

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire hit_drv = (reg_addr == ptst_pkg::ADDR_DRV_TEST);
  wire hit_ctrl2 = (reg_addr == ptst_pkg::ADDR_CTRL2);
  wire wr_drv = reg_wr && hit_drv;
  wire wr_ctrl2 = reg_wr && hit_ctrl2;
  wire rd_drv = reg_rd && hit_drv;
  wire rd_ctrl2 = reg_rd && hit_ctrl2;

  // ----------------------------------------
  // Control field decode
  // ----------------------------------------
  wire nonstop_selftest_mode = ctrl_reg[ptst_pkg::NONSTOP_BIT];
  wire driver_pattern_enable = ctrl_reg[ptst_pkg::PATT_EN_BIT];
  wire pattern_gap_select = ctrl_reg[ptst_pkg::GAP_SEL_BIT];
  wire [1:0] driver_pattern_choice = ctrl_reg[ptst_pkg::CHOICE_MSB:0];

  // Soft reset is busy while the counter runs
  wire soft_busy = (srst_cnt_reg != 5'h00);
  wire soft_req = wr_ctrl2 && reg_wdata[ptst_pkg::SOFT_RST_BIT];

  // Nonstop only counts when the main self-test is running
  wire nonstop_active = nonstop_selftest_mode && selftest_run;
  wire tx_running = selftest_run && !soft_busy;

  // Read words
  wire [15:0] drv_word = {tally_reg, ctrl_reg};
  // Only the soft reset bit is live; all others read zero
  wire [15:0] ctrl2_word = {6'h00, soft_busy, 9'h000};

  // ----------------------------------------
  // Soft reset sequencing
  // ----------------------------------------
  // A write of one starts a fixed-length internal reset. The bit reads
  // back whether the counter runs, so it clears without another write.
  always_comb begin
    srst_cnt_next = srst_cnt_reg;
    if (soft_req) begin
      // A fresh request restarts the full length
      srst_cnt_next = 5'(ptst_pkg::SOFT_RST_CYC);
    end else if (soft_busy) begin
      srst_cnt_next = srst_cnt_reg - 5'h01;
    end
  end

  // ----------------------------------------
  // Mismatch tally
  // ----------------------------------------
  // Start wins over a nibble error in the same cycle, since the error
  // belongs to the packet run that is being abandoned.
  always_comb begin
    tally_next = tally_reg;
    if (selftest_start) begin
      tally_next = ptst_pkg::TALLY_ZERO;
    end else if (selftest_run && rx_nibble_valid && rx_nibble_error) begin
      if (tally_reg != ptst_pkg::TALLY_MAX) begin
        tally_next = tally_reg + ptst_pkg::TALLY_ONE;
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Data stands only in the cycle after the strobe; unmapped reads zero
  always_comb begin
    rdata_next = 16'h0000;
    if (rd_drv) begin
      rdata_next = drv_word;
    end else if (rd_ctrl2) begin
      rdata_next = ctrl2_word;
    end
  end

  // ----------------------------------------
  // Self-test transmitter
  // ----------------------------------------
  // Packets of fixed length with an idle gap between them. In nonstop
  // mode the gap is skipped so the line never goes quiet.
  always_comb begin
    tx_state_next = tx_state_reg;
    tx_cnt_next = tx_cnt_reg + 7'h01;
    prbs_next = prbs_reg;
    tx_data_next = 4'h0;
    unique case (tx_state_reg)
      PTST_T_OFF: begin
        tx_cnt_next = 7'h00;
        if (tx_running) begin
          tx_state_next = PTST_T_SEND;
        end
      end
      PTST_T_SEND: begin
        // Shift four bits per nibble
        prbs_next = {prbs_reg[10:0],
                     prbs_reg[14:11] ^ prbs_reg[13:10]};
        tx_data_next = prbs_reg[3:0];
        if (tx_cnt_reg == 7'(ptst_pkg::PKT_NIBBLES - 1)) begin
          tx_cnt_next = 7'h00;
          if (!nonstop_active) begin
            tx_state_next = PTST_T_GAP;
          end
        end
      end
      PTST_T_GAP: begin
        if (nonstop_active) begin
          tx_state_next = PTST_T_SEND;
          tx_cnt_next = 7'h00;
        end else if (tx_cnt_reg == 7'(ptst_pkg::PKT_GAP_NIBBLES - 1)) begin
          tx_state_next = PTST_T_SEND;
          tx_cnt_next = 7'h00;
        end
      end
      default: begin
        tx_state_next = PTST_T_OFF;
      end
    endcase
    if (!tx_running) begin
      tx_state_next = PTST_T_OFF;
      tx_data_next = 4'h0;
    end
  end

  // ----------------------------------------
  // Register block
  // ----------------------------------------
  // Configuration is not touched by soft reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= ptst_pkg::CTRL_RESET;
    end else if (wr_drv) begin
      // Tally bits are read-only and dropped here
      ctrl_reg <= reg_wdata[ptst_pkg::CTRL_MSB:0];
    end
  end

  // Tally is status, kept across soft reset like the registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tally_reg <= ptst_pkg::TALLY_ZERO;
    end else begin
      tally_reg <= tally_next;
    end
  end

  // Soft reset counter
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      srst_cnt_reg <= 5'h00;
    end else begin
      srst_cnt_reg <= srst_cnt_next;
    end
  end

  // Read data register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Transmit state; soft reset returns it to idle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tx_state_reg <= PTST_T_OFF;
      tx_cnt_reg <= 7'h00;
      prbs_reg <= ptst_pkg::PRBS_SEED;
      tx_data_reg <= 4'h0;
    end else if (soft_busy) begin
      tx_state_reg <= PTST_T_OFF;
      tx_cnt_reg <= 7'h00;
      prbs_reg <= ptst_pkg::PRBS_SEED;
      tx_data_reg <= 4'h0;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_cnt_reg <= tx_cnt_next;
      prbs_reg <= prbs_next;
      tx_data_reg <= tx_data_next;
    end
  end

  // ----------------------------------------
  // Driver test pattern generator
  // ----------------------------------------
  ptst_pattern u_pattern (
    .core_clk(core_clk),
    .resetn(resetn),
    .soft_rst(soft_busy),
    .pattern_enable(driver_pattern_enable),
    .choice(driver_pattern_choice),
    .gap_select(pattern_gap_select),
    .drv_active(line_driver_active),
    .drv_level(line_driver_level)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Guard is only switched off in 10M twisted-pair operation; the
  // setting must be made by software before nonstop runs at 10M.
  assign babble_guard_enable = !(babble_guard_disable && ten_meg_tp_mode);
  assign selftest_tx_en = (tx_state_reg == PTST_T_SEND);
  assign selftest_tx_data = tx_data_reg;
  assign soft_reset_out = soft_busy;
  assign reg_rdata = rdata_reg;

endmodule
`default_nettype wire

// ---- tb/ptst_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module ptst_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Self-test and babble guard
  input wire logic selftest_start,
  input wire logic selftest_run,
  input wire logic rx_nibble_valid,
  input wire logic rx_nibble_error,
  input wire logic babble_guard_disable,
  input wire logic ten_meg_tp_mode,
  input wire logic babble_guard_enable,
  input wire logic selftest_tx_en,
  input wire logic [3:0] selftest_tx_data,
  // Line driver and soft reset
  input wire logic line_driver_active,
  input wire logic line_driver_level,
  input wire logic soft_reset_out
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  logic [5:0] ctrl_seen_reg; // Low six bits of the last control byte written
  logic [9:0] low_cnt_reg; // Low run of the line level
  logic [5:0] sr_cnt_reg; // Cycles of soft reset so far
  logic pulse_seen_reg; // A pulse went out since enable
  wire tone_on = ctrl_seen_reg[4] && (ctrl_seen_reg[1:0] == 2'h3);
  wire link_on = ctrl_seen_reg[4] && (ctrl_seen_reg[1:0] == 2'h2);
  wire nonstop_on = ctrl_seen_reg[5];
  wire [9:0] gap_exp = ctrl_seen_reg[2] ? 10'(ptst_pkg::GAP_LONG_CYC)
                                        : 10'(ptst_pkg::GAP_SHORT_CYC);

  // Shadow of the control byte, so checks follow software intent
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_seen_reg <= 6'h00;
      low_cnt_reg <= 10'h000;
      sr_cnt_reg <= 6'h00;
      pulse_seen_reg <= 1'b0;
    end else begin
      if (reg_wr && (reg_addr == ptst_pkg::ADDR_DRV_TEST)) begin
        ctrl_seen_reg <= reg_wdata[5:0];
      end
      // Idle clears the low run, so only real gaps are measured
      low_cnt_reg <= (line_driver_level || !line_driver_active) ? 10'h000 : low_cnt_reg + 10'h001;
      sr_cnt_reg <= soft_reset_out ? sr_cnt_reg + 6'h01 : 6'h00;
      pulse_seen_reg <= line_driver_active && (pulse_seen_reg || line_driver_level);
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence sr_write;
    reg_wr && (reg_addr == ptst_pkg::ADDR_CTRL2) && reg_wdata[ptst_pkg::SOFT_RST_BIT];
  endsequence
  sequence nlp_pulse;
    line_driver_level [*2] ##1 !line_driver_level;
  endsequence

  guard_map_a: assert property (
    babble_guard_enable == !(babble_guard_disable && ten_meg_tp_mode))
    else $error("babble guard enable does not follow its inputs");
  ctrl2_zero_a: assert property (
    reg_rd && (reg_addr == ptst_pkg::ADDR_CTRL2) |=> (reg_rdata & 16'hFDFF) == 16'h0000)
    else $error("unused control bits read nonzero");
  sr_status_a: assert property (
    reg_rd && (reg_addr == ptst_pkg::ADDR_CTRL2) |=> reg_rdata[9] == $past(soft_reset_out))
    else $error("soft reset status differs from reset activity");
  sr_start_a: assert property (sr_write |=> soft_reset_out [*8])
    else $error("soft reset did not start after the write");
  sr_len_a: assert property ($fell(soft_reset_out) |-> sr_cnt_reg == 6'(ptst_pkg::SOFT_RST_CYC))
    else $error("soft reset length wrong");
  tx_stop_a: assert property (!selftest_run |=> !selftest_tx_en)
    else $error("transmitter active without self-test run");
  nonstop_flow_a: assert property (
    selftest_tx_en && selftest_run && nonstop_on && !soft_reset_out |=> selftest_tx_en)
    else $error("gap in nonstop transmission");
  pattern_off_a: assert property (
    reg_wr && (reg_addr == ptst_pkg::ADDR_DRV_TEST) && !reg_wdata[4]
    |=> ##1 !line_driver_active && !line_driver_level)
    else $error("pattern still running after disable");
  tone_toggle_a: assert property (
    tone_on && $past(tone_on) && line_driver_active && $past(line_driver_active, 2)
    |-> line_driver_level != $past(line_driver_level))
    else $error("tone level did not toggle");
  nlp_width_a: assert property (
    link_on && $past(link_on) && $rose(line_driver_level) |-> nlp_pulse)
    else $error("link pulse width wrong");
  link_gap_a: assert property (
    link_on && $past(link_on) && pulse_seen_reg && $rose(line_driver_level)
    |-> low_cnt_reg == gap_exp)
    else $error("link pulse gap wrong");
endmodule

bind ptst_top ptst_checker u_ptst_checker (.core_clk, .resetn, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .selftest_start, .selftest_run, .rx_nibble_valid,
  .rx_nibble_error, .babble_guard_disable, .ten_meg_tp_mode, .babble_guard_enable,
  .selftest_tx_en, .selftest_tx_data, .line_driver_active, .line_driver_level,
  .soft_reset_out);
`default_nettype wire

// ---- tb/tb_phy_driver_test_and_soft_reset.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_phy_driver_test_and_soft_reset;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [4:0] A_DRV = ptst_pkg::ADDR_DRV_TEST;
  localparam logic [4:0] A_CT2 = ptst_pkg::ADDR_CTRL2;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic selftest_start = 1'b0;
  logic selftest_run = 1'b0;
  logic rx_nibble_valid = 1'b0;
  logic rx_nibble_error = 1'b0;
  logic babble_guard_disable = 1'b0;
  logic ten_meg_tp_mode = 1'b0;
  logic [15:0] reg_rdata;
  logic [3:0] selftest_tx_data;
  logic babble_guard_enable, selftest_tx_en, line_driver_active, line_driver_level;
  logic soft_reset_out;
  int miscompares = 0;
  int cmp_count = 0;

  // 20 MHz clock
  always #25 core_clk = ~core_clk;

  ptst_top u_ptst_top (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .selftest_start, .selftest_run, .rx_nibble_valid, .rx_nibble_error,
    .babble_guard_disable, .ten_meg_tp_mode, .babble_guard_enable, .selftest_tx_en,
    .selftest_tx_data, .line_driver_active, .line_driver_level, .soft_reset_out);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d, miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Wait n edges, then let their updates settle
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // Errored nibbles on back-to-back cycles
  task automatic err_burst(input int n);
    repeat (n) begin
      @(posedge core_clk);
      rx_nibble_valid <= 1'b1;
      rx_nibble_error <= 1'b1;
    end
    @(posedge core_clk);
    rx_nibble_valid <= 1'b0;
    rx_nibble_error <= 1'b0;
  endtask

  task automatic pulse_start();
    @(posedge core_clk);
    selftest_start <= 1'b1;
    @(posedge core_clk);
    selftest_start <= 1'b0;
  endtask

  // Longest high run and last complete low run of the line level
  task automatic run_stats(input int n, output int hi_max, output int lo_last);
    int hi;
    int lo;
    hi = 0;
    lo = 0;
    hi_max = 0;
    lo_last = 0;
    repeat (n) begin
      tick(1);
      if (line_driver_level === 1'b1) begin
        if (lo > 0) lo_last = lo;
        lo = 0;
        hi++;
        if (hi > hi_max) hi_max = hi;
      end else begin
        hi = 0;
        lo++;
      end
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd_chk(A_DRV, 16'h0000);
    rd_chk(A_CT2, 16'h0000);
    wr(A_CT2, 16'hFDFF);
    rd_chk(A_CT2, 16'h0000);
    wr(5'h05, 16'hFFFF);
    rd_chk(5'h05, 16'h0000);
    wr(A_DRV, 16'hFFCB);
    rd_chk(A_DRV, 16'h00CB);
    wr(A_DRV, 16'h0000);
  endtask

  task automatic t_guard();
    for (int i = 0; i < 4; i++) begin
      babble_guard_disable <= i[0];
      ten_meg_tp_mode <= i[1];
      tick(1);
      chk(16'(babble_guard_enable), 16'(i != 3));
    end
  endtask

  task automatic t_tally();
    selftest_run <= 1'b1;
    pulse_start();
    err_burst(3);
    rd_chk(A_DRV, 16'h0300);
    selftest_run <= 1'b0;
    err_burst(2);
    rd_chk(A_DRV, 16'h0300);
    selftest_run <= 1'b1;
    err_burst(260);
    rd_chk(A_DRV, 16'hFF00);
    err_burst(1);
    rd_chk(A_DRV, 16'hFF00);
    pulse_start();
    rd_chk(A_DRV, 16'h0000);
    selftest_run <= 1'b0;
  endtask

  task automatic t_nonstop();
    int gaps;
    int chg;
    logic [3:0] last;
    gaps = 0;
    chg = 0;
    last = 4'h0;
    babble_guard_disable <= 1'b1;
    ten_meg_tp_mode <= 1'b1;
    wr(A_DRV, 16'h0020);
    selftest_run <= 1'b1;
    tick(3);
    repeat (200) begin
      tick(1);
      if (selftest_tx_en !== 1'b1) gaps++;
      // Pseudo-random data must change at least once
      if (selftest_tx_data !== last) chg++;
      last = selftest_tx_data;
    end
    chk(16'(gaps), 16'h0000);
    chk(16'(chg > 0), 16'h0001);
    wr(A_DRV, 16'h0000);
    gaps = 0;
    repeat (ptst_pkg::PKT_NIBBLES + ptst_pkg::PKT_GAP_NIBBLES) begin
      tick(1);
      if (selftest_tx_en === 1'b0) gaps++;
    end
    chk(16'(gaps), 16'(ptst_pkg::PKT_GAP_NIBBLES));
    selftest_run <= 1'b0;
    tick(2);
    chk(16'(selftest_tx_en), 16'h0000);
    chk(16'(selftest_tx_data), 16'h0000);
  endtask

  task automatic t_soft();
    selftest_run <= 1'b1;
    wr(A_DRV, 16'h0013);
    tick(5);
    wr(A_CT2, 16'h0200);
    rd_chk(A_CT2, 16'h0200);
    chk(16'(selftest_tx_en), 16'h0000);
    chk(16'(soft_reset_out), 16'h0001);
    tick(20);
    chk(16'(soft_reset_out), 16'h0000);
    rd_chk(A_CT2, 16'h0000);
    rd_chk(A_DRV, 16'h0013);
    selftest_run <= 1'b0;
    wr(A_DRV, 16'h0000);
  endtask

  // Every choice with both gaps; the generator is stopped between runs
  task automatic t_pattern();
    int hm;
    int ll;
    for (int g = 0; g < 2; g++) begin
      for (int c = 0; c < 4; c++) begin
        wr(A_DRV, 16'(16 + 4 * g + c));
        run_stats(720, hm, ll);
        chk(16'(line_driver_active), 16'h0001);
        if (c < 2) chk(16'((hm - (c ? ptst_pkg::MARK_B_CYC
                                    : ptst_pkg::MARK_A_CYC)) >> 1), 0);
        if (c == 2) chk(16'(hm), 16'(ptst_pkg::NLP_CYC));
        if (c == 2) chk(16'(ll), 16'(g ? ptst_pkg::GAP_LONG_CYC : ptst_pkg::GAP_SHORT_CYC));
        if (c == 3) chk(16'(hm + ll), 16'h0002);
        wr(A_DRV, 16'h0000);
        tick(2);
        chk(16'({line_driver_active, line_driver_level}), 16'h0000);
      end
    end
    wr(A_DRV, 16'h0007);
    tick(10);
    chk(16'(line_driver_active), 16'h0000);
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    tick(5);
    resetn <= 1'b1;
    tick(1);
    t_regs();
    t_guard();
    t_tally();
    t_nonstop();
    t_soft();
    t_pattern();
    close_out();
  end

  // About 6500 cycles are expected; a hang ends the run well after that
  initial begin
    #(50 * 20000);
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
